// [bench/dual_contact_sensor.sv]
/*
  two-contact safety sensor model: contact a follows the commanded level,
  contact b trails it by a programmable skew in clocks.
  assumes level_in and skew_in change just after a rising clk_in edge.
*/
`timescale 1ns/10ps
`default_nettype none
module dual_contact_sensor (
  input wire logic clk_in, // bench clock
  input wire logic level_in, // commanded contact state
  input wire logic [7:0] skew_in, // contact b lags contact a by this many clocks plus one
  output logic [1:0] ch_out // contact a in bit 0, b in bit 1
);
  logic [7:0] lag_q; // clocks left before contact b follows
  initial begin
    ch_out = 2'b00;
    lag_q = 8'h00;
  end
  // contacts never switch together; a long skew acts like a broken wire
  always @(posedge clk_in) begin
    if (level_in !== ch_out[0]) begin
      ch_out[0] <= level_in;
      lag_q <= skew_in;
    end else if (lag_q != 8'h00) begin
      lag_q <= lag_q - 8'h01;
    end else begin
      ch_out[1] <= ch_out[0];
    end
  end
endmodule : dual_contact_sensor
`default_nettype wire

// [bench/safe_dual_input_filter_test.sv]
/*
  self-checking bench: register bus, debounce, discrepancy, toggle rate,
  config gating, shared access and standard input separation.
  assumes the sensor model on the safe channels; ms ticks shortened to 8 clocks.
*/
`timescale 1ns/10ps
`default_nettype none
module safe_dual_input_filter_test;
  localparam int MSC = 8; // clocks per ms tick
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat; // read data seen
  logic ack; // bus answer seen
  logic level = 1'b0; // sensor command
  logic [7:0] skew = 8'h00; // contact b lag
  logic [1:0] ch; // contacts into the block
  logic [1:0] std = 2'b00;
  logic [1:0] std_f;
  logic cfg_v = 1'b0;
  logic [15:0] cfg_a = 16'h0000;
  logic [4:0] outs; // shared, monitor, toggle, wiring, torque off
  logic [31:0] exp_q[$]; // read results still owed
  int mismatches = 0;
  int checked = 0;

  always #4 clk = ~clk;

  dual_contact_sensor i_dual_contact_sensor (.clk_in(clk), .level_in(level), .skew_in(skew), .ch_out(ch));

  safe_dual_input_filter #(.MS_CYCLES(MSC), .STD_INPUTS(2), .TOGGLE_WINDOW_MS(16), .TOGGLE_MAX(8'h14))
    i_safe_dual_input_filter (.clk_in(clk), .rstn_in(rstn), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .safe_ch_in(ch), .std_in(std), .std_out(std_f), .cfg_valid_in(cfg_v),
    .cfg_addr_in(cfg_a), .torque_off_out(outs[0]), .wiring_fault_out(outs[1]),
    .toggle_fault_out(outs[2]), .comm_monitor_en_out(outs[3]), .shared_device_en_out(outs[4]));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      stop_test();
    end
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // bounded wait for one output to reach a level
  task automatic wait_out(input int k, input logic v, input int bound);
    int n;
    n = 0;
    while (outs[k] !== v && n < bound) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, outs[k]}, {31'h0, v});
    if (n >= bound) stop_test();
  endtask : wait_out

  // output must not leave its level for n clocks
  task automatic hold_out(input int k, input logic v, input int n);
    logic seen;
    seen = v;
    repeat (n) begin
      @(posedge clk);
      if (outs[k] !== v) seen = outs[k];
    end
    check({31'h0, seen}, {31'h0, v});
  endtask : hold_out

  task automatic send_cfg(input logic [15:0] a);
    @(posedge clk);
    cfg_v <= 1'b1;
    cfg_a <= a;
    @(posedge clk);
    cfg_v <= 1'b0;
  endtask : send_cfg

  // read answers are matched against the oldest owed value
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      check(rdat, exp_q.pop_front());
    end
  end

  initial begin
    logic [15:0] dest;
    logic [1:0] sv;
    void'($urandom(43));
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd(safe_input_pkg::OFS_DEST_ADDR, 32'h0000_0000);
    rd(safe_input_pkg::OFS_TOLERANCE, 32'h0000_01F4);
    rd(safe_input_pkg::OFS_SAFE_DEB, 32'h0000_0001);
    rd(safe_input_pkg::OFS_STATUS, 32'h0000_0002);
    rd(8'h1C, 32'h0000_0000);
    $display("test reset done");
    level <= 1'b1;
    wait_out(0, 1'b0, 64);
    rd(safe_input_pkg::OFS_STATUS, 32'h0000_0081);
    wb(1'b1, safe_input_pkg::OFS_SAFE_DEB, 32'h0000_0003);
    wb(1'b1, safe_input_pkg::OFS_TOLERANCE, 32'h0000_0003);
    rd(safe_input_pkg::OFS_SAFE_DEB, 32'h0000_0003);
    rd(safe_input_pkg::OFS_TOLERANCE, 32'h0000_0003);
    rd(safe_input_pkg::OFS_STD_DEB, 32'h0000_0004);
    $display("test release done");
    // a test pulse shorter than the debounce time
    skew <= 8'hFF;
    level <= 1'b0;
    repeat (MSC) @(posedge clk);
    level <= 1'b1;
    hold_out(0, 1'b0, 40);
    $display("test pulse done");
    level <= 1'b0;
    hold_out(0, 1'b0, 10);
    wait_out(0, 1'b1, 40);
    hold_out(1, 1'b0, 16);
    wait_out(1, 1'b1, 80);
    skew <= 8'h00;
    level <= 1'b1;
    repeat (5 * MSC) @(posedge clk);
    wb(1'b1, safe_input_pkg::OFS_CONTROL, 32'h0000_0001);
    wait_out(0, 1'b0, 40);
    $display("test discrepancy done");
    skew <= 8'hFF;
    // enough changes that either side of a window boundary exceeds the limit
    repeat (60) begin
      @(posedge clk);
      level <= ~level;
    end
    wait_out(2, 1'b1, 20);
    wait_out(0, 1'b1, 8);
    repeat (20 * MSC) @(posedge clk);
    wb(1'b1, safe_input_pkg::OFS_CONTROL, 32'h0000_0001);
    wait_out(2, 1'b0, 8);
    wait_out(0, 1'b0, 40);
    $display("test toggle done");
    wb(1'b1, safe_input_pkg::OFS_STD_DEB, 32'h0000_0000);
    repeat (4) begin
      sv = 2'($urandom);
      std <= sv;
      repeat (3) @(posedge clk);
      check({30'h0, std_f}, {30'h0, sv});
    end
    $display("test std done");
    dest = 16'($urandom);
    wb(1'b1, safe_input_pkg::OFS_DEST_ADDR, {16'h0000, dest});
    rd(safe_input_pkg::OFS_DEST_ADDR, {16'h0000, dest});
    send_cfg(dest ^ 16'h0001);
    hold_out(3, 1'b0, 4);
    rd(safe_input_pkg::OFS_STATUS, 32'h0000_00C1);
    send_cfg(dest);
    wait_out(3, 1'b1, 2);
    $display("test config done");
    wb(1'b1, safe_input_pkg::OFS_SHARED, 32'h0000_0001);
    hold_out(4, 1'b0, 2);
    wb(1'b1, safe_input_pkg::OFS_SHARED, 32'h0000_0002);
    wait_out(4, 1'b1, 2);
    $display("test shared done");
    stop_test();
  end
endmodule : safe_dual_input_filter_test
`default_nettype wire

// [design/input_debounce.sv]
/*
  one-channel debounce filter counting millisecond ticks.
  assumes raw_in synchronous to clk_in and tick_in a one-cycle pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module input_debounce (
  input wire logic clk_in, // system clock
  input wire logic rstn_in, // synchronous reset, active low
  input wire logic tick_in, // one pulse per millisecond
  input wire logic raw_in, // unfiltered level
  input wire logic [15:0] limit_in, // stable time in ticks, 0 passes at once
  output logic level_out // filtered level
);

  typedef struct packed {
    logic level; // accepted level
    logic [15:0] cnt; // ticks the new level has held
  } deb_state_type;

  deb_state_type s_q; // registered state
  deb_state_type s_d; // next state

  // next-state logic
  always_comb begin
    s_d = s_q;
    // R15 reset count on any return
    if (raw_in == s_q.level) begin
      s_d.cnt = 16'h0000;
    end else if (limit_in == 16'h0000) begin
      // filtering switched off
      s_d.level = raw_in;
    end else if (tick_in) begin
      // R5 pass only after full time
      if (({1'b0, s_q.cnt} + 17'h0_0001) >= {1'b0, limit_in}) begin
        s_d.level = raw_in;
        s_d.cnt = 16'h0000;
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
    end
  end

  // state register; low is the safe level after reset
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_out = s_q.level;

  chk_filter_new_level: assert property (@(posedge clk_in) disable iff (!rstn_in) // R15
    $changed(s_q.level) |-> $past(raw_in) == s_q.level)
    else $error("filtered level took a value the input did not show");

  chk_filter_hold_short: assert property (@(posedge clk_in) disable iff (!rstn_in) // R5
    (raw_in != s_q.level && limit_in != 16'h0000 && !tick_in) |=> $stable(s_q.level))
    else $error("filtered level moved without a tick");

endmodule : input_debounce
`default_nettype wire

// [design/safe_dual_input_filter.sv]
/*
  two-channel safe input processing for the torque shutdown path: debounce,
  discrepancy monitoring, toggle-rate monitoring, torque-off state, and the
  gate on safety comm monitoring. registers sit on a classic wishbone slave.
  assumes all inputs synchronous to clk_in; a config decoder delivers cfg_*.

// Notes on behaviour
// R1 - both channels compared for equal level
// R2 - lasting disagreement beyond tolerance flags wiring fault
// R3 - either channel low selects torque off
// R4 - tolerance time register, 500 ms at reset
// R5 - short changes filtered, response delayed by debounce
// R6 - debounce time register, 1 ms at reset
// R7 - too many changes in window raises fault
// R8 - controller test pulses last about 1/4 ms
// R9 - standard and safe debounce kept apart
// R10 - status bit shows torque off active
// R11 - destination address register, zero at reset
// R12 - controller sends config before safe comm
// R13 - comm monitoring only after config received
// R14 - shared access value 2 enables shared device
// R15 - new level needs whole stable tick count
*/
`timescale 1ns/10ps
`default_nettype none
module safe_dual_input_filter #(
  parameter int MS_CYCLES = safe_input_pkg::MS_CYCLES, // clocks per ms tick
  parameter int STD_INPUTS = 2, // standard digital inputs
  parameter int TOGGLE_WINDOW_MS = safe_input_pkg::TOGGLE_WINDOW_MS, // window length
  parameter logic [7:0] TOGGLE_MAX = 8'(safe_input_pkg::TOGGLE_MAX) // changes allowed per window
) (
  input wire logic clk_in, // system clock, 125 MHz
  input wire logic rstn_in, // synchronous reset, active low
  input wire logic wb_cyc_in, // wishbone cycle
  input wire logic wb_stb_in, // wishbone strobe
  input wire logic wb_we_in, // wishbone write
  input wire logic [7:0] wb_adr_in, // wishbone byte address
  input wire logic [3:0] wb_sel_in, // wishbone byte enables
  input wire logic [31:0] wb_dat_in, // wishbone write data
  output logic [31:0] wb_dat_out, // wishbone read data
  output logic wb_ack_out, // wishbone acknowledge
  input wire logic [1:0] safe_ch_in, // the two safe input channels
  input wire logic [STD_INPUTS-1:0] std_in, // standard inputs, raw
  output logic [STD_INPUTS-1:0] std_out, // standard inputs, filtered
  input wire logic cfg_valid_in, // safety config telegram received, pulse
  input wire logic [15:0] cfg_addr_in, // destination address in the config
  output logic torque_off_out, // torque shutdown request
  output logic wiring_fault_out, // discrepancy fault, sticky
  output logic toggle_fault_out, // toggle-rate fault, sticky
  output logic comm_monitor_en_out, // safety comm monitoring running
  output logic shared_device_en_out // shared device access enabled
);

  localparam int NCH = 2 + STD_INPUTS; // all filtered channels
  localparam int TW = $clog2(MS_CYCLES); // tick counter width
  localparam logic [TW-1:0] TICK_LAST = TW'(MS_CYCLES - 1);
  localparam logic [15:0] WIN_LAST = 16'(TOGGLE_WINDOW_MS - 1);

  // refuse settings the counters cannot serve
  if (MS_CYCLES < 2 || STD_INPUTS < 1 || TOGGLE_WINDOW_MS < 1 || TOGGLE_WINDOW_MS > 65535) begin : g_bad
    $error("safe_dual_input_filter: unsupported parameter value");
  end

  typedef struct packed {
    safe_input_pkg::torque_state_type st; // torque path state
    logic [15:0] dest; // safety_dest_address_reg
    logic [15:0] shared; // shared_access_config
    logic [15:0] tol; // channel_tolerance_time
    logic [15:0] deb; // safe_input_debounce_time
    logic [15:0] std_deb; // std_input_debounce_time
    logic [TW-1:0] tick_cnt; // clocks within the ms
    logic tick; // ms tick pulse
    logic [15:0] disc_cnt; // ms of disagreement
    logic disc_fault; // wiring fault
    logic [15:0] win_cnt; // ms within toggle window
    logic [7:0] edge_cnt; // raw changes in window
    logic tog_fault; // toggle fault
    logic [1:0] raw_prev; // raw channels last cycle
    logic cfg_rcvd; // config accepted
    logic addr_err; // config for another address
    logic ack; // bus acknowledge
    logic [31:0] rdat; // bus read data
    logic torque_off; // registered shutdown request
    logic shared_en; // registered shared enable
  } state_type;

  state_type s_q; // registered state
  state_type s_d; // next state
  logic [NCH-1:0] raw_all; // every channel before filtering
  logic [NCH-1:0] filt; // every channel after filtering
  logic [1:0] safe_f; // filtered safe channels
  logic bus_req; // new bus access this cycle
  logic bus_wr; // new write access
  logic [1:0] toggles; // raw changes this cycle
  logic [31:0] status; // status word as it stands

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction : merge16

  // word-aligned address match
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction : hit

  assign raw_all = {std_in, safe_ch_in};
  assign safe_f = filt[1:0];

  // one filter per channel, safe and standard timings apart
  for (genvar i = 0; i < NCH; i++) begin : g_deb
    logic [15:0] limit; // debounce time for this channel
    // R9 separate debounce per class
    assign limit = (i < 2) ? s_q.deb : s_q.std_deb;
    input_debounce u_deb (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .tick_in(s_q.tick),
      .raw_in(raw_all[i]),
      .limit_in(limit),
      .level_out(filt[i])
    );
  end

  assign std_out = filt[NCH-1:2];
  assign bus_req = wb_cyc_in && wb_stb_in && !s_q.ack;
  assign bus_wr = bus_req && wb_we_in;
  assign toggles = s_q.raw_prev ^ safe_ch_in;

  // status word assembly
  always_comb begin
    status = 32'h0000_0000;
    status[safe_input_pkg::STAT_CH_A] = safe_f[0];
    status[safe_input_pkg::STAT_CH_B] = safe_f[1];
    // R10 torque off visible to software
    status[safe_input_pkg::STAT_TORQUE_OFF] = s_q.torque_off;
    status[safe_input_pkg::STAT_WIRING] = s_q.disc_fault;
    status[safe_input_pkg::STAT_TOGGLE] = s_q.tog_fault;
    status[safe_input_pkg::STAT_MONITOR] = s_q.cfg_rcvd;
    status[safe_input_pkg::STAT_SHARED] = s_q.shared_en;
    status[safe_input_pkg::STAT_ADDR_ERR] = s_q.addr_err;
  end

  // next-state logic for the whole block
  always_comb begin
    s_d = s_q;
    // millisecond time base
    s_d.tick = 1'b0;
    if (s_q.tick_cnt == TICK_LAST) begin
      s_d.tick_cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + TW'(1);
    end

    // bus slave: answer one cycle after the request, unmapped reads zero
    s_d.ack = bus_req;
    s_d.rdat = 32'h0000_0000;
    if (bus_req && !wb_we_in) begin
      if (hit(wb_adr_in, safe_input_pkg::OFS_DEST_ADDR)) begin
        s_d.rdat = {16'h0000, s_q.dest};
      end else if (hit(wb_adr_in, safe_input_pkg::OFS_SHARED)) begin
        s_d.rdat = {16'h0000, s_q.shared};
      end else if (hit(wb_adr_in, safe_input_pkg::OFS_TOLERANCE)) begin
        s_d.rdat = {16'h0000, s_q.tol};
      end else if (hit(wb_adr_in, safe_input_pkg::OFS_SAFE_DEB)) begin
        s_d.rdat = {16'h0000, s_q.deb};
      end else if (hit(wb_adr_in, safe_input_pkg::OFS_STD_DEB)) begin
        s_d.rdat = {16'h0000, s_q.std_deb};
      end else if (hit(wb_adr_in, safe_input_pkg::OFS_STATUS)) begin
        s_d.rdat = status;
      end
    end
    if (bus_wr) begin
      // R11 destination address register
      if (hit(wb_adr_in, safe_input_pkg::OFS_DEST_ADDR)) begin
        s_d.dest = merge16(s_q.dest, wb_dat_in, wb_sel_in);
      end
      if (hit(wb_adr_in, safe_input_pkg::OFS_SHARED)) begin
        s_d.shared = merge16(s_q.shared, wb_dat_in, wb_sel_in);
      end
      // R4 tolerance time setting
      if (hit(wb_adr_in, safe_input_pkg::OFS_TOLERANCE)) begin
        s_d.tol = merge16(s_q.tol, wb_dat_in, wb_sel_in);
      end
      // R6 safe debounce setting
      if (hit(wb_adr_in, safe_input_pkg::OFS_SAFE_DEB)) begin
        s_d.deb = merge16(s_q.deb, wb_dat_in, wb_sel_in);
      end
      if (hit(wb_adr_in, safe_input_pkg::OFS_STD_DEB)) begin
        s_d.std_deb = merge16(s_q.std_deb, wb_dat_in, wb_sel_in);
      end
      // clears come first so that a same-cycle event below wins
      if (hit(wb_adr_in, safe_input_pkg::OFS_CONTROL) && wb_sel_in[0]) begin
        if (wb_dat_in[safe_input_pkg::CTRL_CLR_FAULT]) begin
          s_d.disc_fault = 1'b0;
          s_d.tog_fault = 1'b0;
        end
        if (wb_dat_in[safe_input_pkg::CTRL_CLR_ADDR]) begin
          s_d.addr_err = 1'b0;
        end
      end
    end

    // R1 channel equality check
    if (safe_f[0] != safe_f[1]) begin
      if (s_q.tick) begin
        // R2 disagreement past tolerance
        if (s_q.disc_cnt >= s_q.tol) begin
          s_d.disc_fault = 1'b1;
        end else begin
          s_d.disc_cnt = s_q.disc_cnt + 16'h0001;
        end
      end
    end else begin
      s_d.disc_cnt = 16'h0000;
    end

    // R7 count raw changes per window
    s_d.raw_prev = safe_ch_in;
    if (s_q.edge_cnt < 8'hFE) begin
      s_d.edge_cnt = s_q.edge_cnt + {7'h00, toggles[0]} + {7'h00, toggles[1]};
    end
    if (s_q.tick) begin
      if (s_q.win_cnt == WIN_LAST) begin
        s_d.win_cnt = 16'h0000;
        s_d.edge_cnt = 8'h00;
      end else begin
        s_d.win_cnt = s_q.win_cnt + 16'h0001;
      end
    end
    if (s_q.edge_cnt > TOGGLE_MAX) begin
      s_d.tog_fault = 1'b1;
    end

    // R12 config arrives before safe comm
    if (cfg_valid_in) begin
      // R13 monitoring gated on accepted config
      if (cfg_addr_in == s_q.dest) begin
        s_d.cfg_rcvd = 1'b1;
      end else begin
        s_d.addr_err = 1'b1;
      end
    end

    // R14 shared device on value 2
    s_d.shared_en = (s_d.shared == safe_input_pkg::SHARED_ENABLE_CODE);

    // torque path; a fault holds torque off until cleared
    unique case (s_q.st)
      safe_input_pkg::ST_RUN: begin
        if (s_q.disc_fault || s_q.tog_fault) begin
          s_d.st = safe_input_pkg::ST_FAULT;
        end else if (safe_f != 2'b11) begin
          // R3 either channel low selects
          s_d.st = safe_input_pkg::ST_OFF;
        end
      end
      safe_input_pkg::ST_OFF: begin
        if (s_q.disc_fault || s_q.tog_fault) begin
          s_d.st = safe_input_pkg::ST_FAULT;
        end else if (safe_f == 2'b11) begin
          s_d.st = safe_input_pkg::ST_RUN;
        end
      end
      safe_input_pkg::ST_FAULT: begin
        if (!s_q.disc_fault && !s_q.tog_fault) begin
          s_d.st = safe_input_pkg::ST_OFF;
        end
      end
      default: begin
        // a corrupted code falls to the safe state
        s_d.st = safe_input_pkg::ST_FAULT;
      end
    endcase
    // R10 active bit follows state
    s_d.torque_off = (s_d.st != safe_input_pkg::ST_RUN);
  end

  // state register; torque starts off until both channels read high
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s_q <= '0;
      s_q.st <= safe_input_pkg::ST_OFF;
      s_q.torque_off <= 1'b1;
      s_q.dest <= safe_input_pkg::RST_DEST_ADDR;
      s_q.shared <= safe_input_pkg::RST_SHARED;
      s_q.tol <= safe_input_pkg::RST_TOLERANCE;
      s_q.deb <= safe_input_pkg::RST_SAFE_DEB;
      s_q.std_deb <= safe_input_pkg::RST_STD_DEB;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_out = s_q.rdat;
  assign wb_ack_out = s_q.ack;
  assign torque_off_out = s_q.torque_off;
  assign wiring_fault_out = s_q.disc_fault;
  assign toggle_fault_out = s_q.tog_fault;
  assign comm_monitor_en_out = s_q.cfg_rcvd;
  assign shared_device_en_out = s_q.shared_en;

  sequence seq_status_read;
    wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_we_in && hit(wb_adr_in, safe_input_pkg::OFS_STATUS);
  endsequence

  sequence seq_either_low;
    s_q.st == safe_input_pkg::ST_RUN && safe_f != 2'b11;
  endsequence

  chk_select_at_once: assert property (@(posedge clk_in) disable iff (!rstn_in) // R3
    seq_either_low |=> torque_off_out ##0 s_q.st != safe_input_pkg::ST_RUN)
    else $error("torque off not selected one cycle after a channel fell");

  chk_wiring_fault_cause: assert property (@(posedge clk_in) disable iff (!rstn_in) // R2
    $rose(wiring_fault_out) |-> $past(safe_f[0] != safe_f[1]) && $past(s_q.disc_cnt) >= $past(s_q.tol))
    else $error("wiring fault without lasting disagreement");

  chk_tolerance_reset: assert property (@(posedge clk_in) // R4
    $rose(rstn_in) |-> s_q.tol == safe_input_pkg::RST_TOLERANCE)
    else $error("tolerance time not 500 ms after reset");

  chk_debounce_reset: assert property (@(posedge clk_in) // R6
    $rose(rstn_in) |-> s_q.deb == safe_input_pkg::RST_SAFE_DEB && s_q.dest == safe_input_pkg::RST_DEST_ADDR)
    else $error("debounce or destination reset value wrong");

  chk_toggle_fault_cause: assert property (@(posedge clk_in) disable iff (!rstn_in) // R7
    $rose(toggle_fault_out) |-> $past(s_q.edge_cnt) > TOGGLE_MAX)
    else $error("toggle fault without excess changes");

  chk_status_active_bit: assert property (@(posedge clk_in) disable iff (!rstn_in) // R10
    seq_status_read |=> wb_ack_out && wb_dat_out[safe_input_pkg::STAT_TORQUE_OFF] == $past(torque_off_out))
    else $error("status bit does not show torque off");

  chk_foreign_config: assert property (@(posedge clk_in) disable iff (!rstn_in) // R11
    (cfg_valid_in && cfg_addr_in != s_q.dest && !comm_monitor_en_out) |=> !comm_monitor_en_out ##0 s_q.addr_err)
    else $error("config for another address was accepted");

  chk_monitor_gate: assert property (@(posedge clk_in) disable iff (!rstn_in) // R13
    $rose(comm_monitor_en_out) |-> $past(cfg_valid_in) && $past(cfg_addr_in) == $past(s_q.dest))
    else $error("comm monitoring started without config");

  chk_shared_enable: assert property (@(posedge clk_in) disable iff (!rstn_in) // R14
    $changed(s_q.shared) |-> shared_device_en_out == (s_q.shared == safe_input_pkg::SHARED_ENABLE_CODE))
    else $error("shared device enable does not follow value 2");

  chk_bus_ack_single: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");

  // a safe debounce write must leave the standard setting alone
  chk_std_deb_apart: assert property (@(posedge clk_in) disable iff (!rstn_in) // R9
    bus_wr && hit(wb_adr_in, safe_input_pkg::OFS_SAFE_DEB) |=> $stable(s_q.std_deb))
    else $error("safe debounce write changed the standard debounce");

endmodule : safe_dual_input_filter
`default_nettype wire

// [design/safe_input_pkg.sv]
/*
  shared constants for the dual-channel safe input block: register offsets,
  status field positions, reset values, state codes and timing counts.
  assumes a 125 MHz system clock; nothing else is shared between files.
*/
package safe_input_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFS_DEST_ADDR = 8'h00; // safety_dest_address_reg
  localparam logic [7:0] OFS_SHARED = 8'h04; // shared_access_config
  localparam logic [7:0] OFS_TOLERANCE = 8'h08; // channel_tolerance_time, ms
  localparam logic [7:0] OFS_SAFE_DEB = 8'h0C; // safe_input_debounce_time, ms
  localparam logic [7:0] OFS_STD_DEB = 8'h10; // std_input_debounce_time, ms
  localparam logic [7:0] OFS_STATUS = 8'h14; // safety_status_word, read only
  localparam logic [7:0] OFS_CONTROL = 8'h18; // write-one-to-clear strobes

  // status word field positions
  localparam int STAT_CH_A = 0; // filtered channel a level
  localparam int STAT_TORQUE_OFF = 1; // torque_off_active_bit
  localparam int STAT_WIRING = 2; // discrepancy fault, sticky
  localparam int STAT_TOGGLE = 3; // too many changes, sticky
  localparam int STAT_MONITOR = 4; // comm monitoring running
  localparam int STAT_SHARED = 5; // shared device enabled
  localparam int STAT_ADDR_ERR = 6; // config with foreign address seen
  localparam int STAT_CH_B = 7; // filtered channel b level

  // control word field positions
  localparam int CTRL_CLR_FAULT = 0; // clear wiring and toggle faults
  localparam int CTRL_CLR_ADDR = 1; // clear address error

  // reset values and the shared enable code
  localparam logic [15:0] RST_DEST_ADDR = 16'h0000;
  localparam logic [15:0] RST_SHARED = 16'h0000;
  localparam logic [15:0] RST_TOLERANCE = 16'h01F4; // 500 ms
  localparam logic [15:0] RST_SAFE_DEB = 16'h0001; // 1 ms
  localparam logic [15:0] RST_STD_DEB = 16'h0004; // 4 ms
  localparam logic [15:0] SHARED_ENABLE_CODE = 16'h0002;

  // timing: one tick per millisecond at an 8 ns clock
  localparam int TICK_MS = 1;
  localparam int CLK_PERIOD_PS = 8000;
  localparam int MS_CYCLES = (TICK_MS * 1000000000) / CLK_PERIOD_PS;
  localparam int TOGGLE_WINDOW_MS = 1000;
  localparam int TOGGLE_MAX = 20;

  // torque path states, one-hot
  typedef enum logic [2:0] {
    ST_RUN = 3'h1, // both channels high, torque allowed
    ST_OFF = 3'h2, // torque_off_function selected
    ST_FAULT = 3'h4 // latched fault, torque off
  } torque_state_type;

endpackage : safe_input_pkg
